/* File: inc/frt_ctrl_pkg.sv */
// Package of constants and types for the timer channel control and status block
package frt_ctrl_pkg;

	// Register select codes on the 8-bit register port
	localparam logic REG_TIMER_CONTROL = 1'h0;
	localparam logic REG_TIMER_CONTROL_STATUS = 1'h1;

	// Reset values of both registers
	localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
	localparam logic [7:0] TIMER_CONTROL_STATUS_RESET = 8'h00;

	// Control register field positions
	localparam int CAPTURE_IRQ_ENABLE_BIT = 7;
	localparam int MATCH_B_IRQ_ENABLE_BIT = 6;
	localparam int MATCH_A_IRQ_ENABLE_BIT = 5;
	localparam int WRAP_IRQ_ENABLE_BIT = 4;
	localparam int MATCH_B_PIN_ENABLE_BIT = 3;
	localparam int MATCH_A_PIN_ENABLE_BIT = 2;
	localparam int CLOCK_SELECT_HI_BIT = 1;
	localparam int CLOCK_SELECT_LO_BIT = 0;

	// Status register field positions
	localparam int CAPTURE_FLAG_BIT = 7;
	localparam int MATCH_B_FLAG_BIT = 6;
	localparam int MATCH_A_FLAG_BIT = 5;
	localparam int WRAP_FLAG_BIT = 4;
	localparam int MATCH_B_LEVEL_BIT = 3;
	localparam int MATCH_A_LEVEL_BIT = 2;
	localparam int CAPTURE_EDGE_SELECT_BIT = 1;
	localparam int CLEAR_ON_MATCH_A_BIT = 0;

	// Flag field of the status register and its plain read/write part
	localparam int FLAG_HI_BIT = 7;
	localparam int FLAG_LO_BIT = 4;
	localparam int FLAG_COUNT = 4;
	localparam logic [3:0] PLAIN_FIELD_MASK = 4'hF;

	// Prescaler width and the tick masks for the three internal rates
	localparam int PRESCALE_WIDTH = 5;
	localparam logic [4:0] DIV4_MASK = 5'h03;
	localparam logic [4:0] DIV8_MASK = 5'h07;
	localparam logic [4:0] DIV32_MASK = 5'h1F;

	// Clock source codes
	typedef enum logic [1:0] {
		CLK_DIV4 = 2'b00,
		CLK_DIV8 = 2'b01,
		CLK_DIV32 = 2'b10,
		CLK_EXTERNAL = 2'b11
	} clock_select_t;

	// Capture edge codes
	localparam logic EDGE_FALLING = 1'h0;
	localparam logic EDGE_RISING = 1'h1;

endpackage : frt_ctrl_pkg

/* File: logic/pin_edge_sync.sv */
// Two-stage pin synchroniser with rising and falling edge pulses
`timescale 1ns/1ns
`default_nettype none

module pin_edge_sync (
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic pin_in,
	output logic level_out,
	output logic rise_out,
	output logic fall_out
);

	logic meta_r;
	logic sync_r;
	logic prev_r;

	// First stage feeds only the second stage
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			meta_r <= 1'h0;
			sync_r <= 1'h0;
		end else begin
			meta_r <= pin_in;
			sync_r <= meta_r;
		end
	end

	// Delayed copy of the synchronised level for edge detection
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			prev_r <= 1'h0;
		end else begin
			prev_r <= sync_r;
		end
	end

	// Edge pulses last one clock
	assign level_out = sync_r;
	assign rise_out = sync_r & ~prev_r;
	assign fall_out = ~sync_r & prev_r;

endmodule : pin_edge_sync

`default_nettype wire

/* File: logic/frt_ctrl.sv */
// Control and status logic of one free-running timer channel
//
// Overview of operation
// - Capture request is high only while capture enable and capture flag are both set.
// - Match B request is high only while its enable and match B flag are set.
// - Match A request is high only while its enable and match A flag are set.
// - Wrap request is high only while its enable and wrap flag are set.
// - With pin enable B set, a match B drives the chosen level on pin B.
// - With pin enable A set, a match A drives the chosen level on pin A.
// - Clock select picks clock over 4, 8, 32, or rising external edges.
// - Control register becomes zero at reset and on standby entry.
// - Control/status register becomes zero at reset and on standby entry.
// - A CPU write clears flags only with zero; writing one is ignored; low bits plain.
// - Capture flag sets whenever a capture copies the counter.
// - A zero write clears a flag only after the CPU read it as one.
// - Transfer controller service clears capture, match A or match B flag.
// - Match B flag sets when counter equals compare B value.
// - Match A flag sets when counter equals compare A value.
// - Wrap flag sets at all-ones to zero; transfer controller never clears it.
// - Status bit 3 sets level driven on pin B at a match.
// - Status bit 2 sets level driven on pin A at a match.
// - Status bit 1 picks capture edge: zero falling, one rising.
// - With status bit 0 set, the counter clears at each match A.
// - Match fires in the last cycle of equality, just before the counter advances.
// - Both match pins sit low from reset until their first match.
// - A capture edge copies the counter even while the capture flag is set.
`timescale 1ns/1ns
`default_nettype none

module frt_ctrl #(
	parameter int COUNT_WIDTH = 16
) (
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic standby_in,
	input wire logic reg_sel_in,
	input wire logic reg_rd_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	input wire logic [COUNT_WIDTH-1:0] running_counter_in,
	input wire logic [COUNT_WIDTH-1:0] compare_a_value_in,
	input wire logic [COUNT_WIDTH-1:0] compare_b_value_in,
	input wire logic ext_clock_pin_in,
	input wire logic capture_pin_in,
	input wire logic xfer_clear_capture_in,
	input wire logic xfer_clear_match_a_in,
	input wire logic xfer_clear_match_b_in,
	output logic count_pulse_out,
	output logic counter_clear_out,
	output logic capture_load_out,
	output logic match_a_pin_out,
	output logic match_b_pin_out,
	output logic capture_irq_out,
	output logic match_a_irq_out,
	output logic match_b_irq_out,
	output logic wrap_irq_out
);

	// Refuse counter widths the compare and wrap logic cannot serve
	if (COUNT_WIDTH < 2 || COUNT_WIDTH > 32) begin : g_width_check
		$error("frt_ctrl: COUNT_WIDTH must lie between 2 and 32");
	end

	// Index of each flag inside the flag field
	localparam int FIDX_WRAP = frt_ctrl_pkg::WRAP_FLAG_BIT - frt_ctrl_pkg::FLAG_LO_BIT;
	localparam int FIDX_MATCH_A = frt_ctrl_pkg::MATCH_A_FLAG_BIT - frt_ctrl_pkg::FLAG_LO_BIT;
	localparam int FIDX_MATCH_B = frt_ctrl_pkg::MATCH_B_FLAG_BIT - frt_ctrl_pkg::FLAG_LO_BIT;
	localparam int FIDX_CAPTURE = frt_ctrl_pkg::CAPTURE_FLAG_BIT - frt_ctrl_pkg::FLAG_LO_BIT;

	// Prescaler tick for an internal source, from the free divider value
	function automatic logic prescale_tick(
		input logic [1:0] sel,
		input logic [frt_ctrl_pkg::PRESCALE_WIDTH-1:0] div
	);
		logic [frt_ctrl_pkg::PRESCALE_WIDTH-1:0] mask;
		mask = frt_ctrl_pkg::DIV4_MASK;
		case (sel)
			frt_ctrl_pkg::CLK_DIV4: begin
				mask = frt_ctrl_pkg::DIV4_MASK;
			end
			frt_ctrl_pkg::CLK_DIV8: begin
				mask = frt_ctrl_pkg::DIV8_MASK;
			end
			frt_ctrl_pkg::CLK_DIV32: begin
				mask = frt_ctrl_pkg::DIV32_MASK;
			end
			default: begin
				mask = frt_ctrl_pkg::DIV4_MASK;
			end
		endcase
		prescale_tick = ((div & mask) == mask);
	endfunction : prescale_tick

	// Register write decode, used for both registers
	function automatic logic reg_write_hit(
		input logic wr,
		input logic sel,
		input logic want
	);
		reg_write_hit = wr & (sel == want);
	endfunction : reg_write_hit

	logic [7:0] timer_control_r;
	logic [3:0] flags_r;
	logic [3:0] flags_nxt;
	logic [3:0] plain_r;
	logic [3:0] read_armed_r;
	logic [3:0] read_armed_nxt;
	logic [3:0] flag_set;
	logic [3:0] flag_clear;
	logic [frt_ctrl_pkg::PRESCALE_WIDTH-1:0] prescale_r;
	logic count_pulse_r;
	logic count_pulse_nxt;
	logic counter_clear_r;
	logic counter_clear_nxt;
	logic capture_load_r;
	logic match_a_pin_r;
	logic match_b_pin_r;
	logic [7:0] reg_rdata_r;
	logic [3:0] irq_r;
	logic ext_level;
	logic ext_rise;
	logic cap_level;
	logic cap_rise;
	logic cap_fall;
	logic capture_event;
	logic match_a_event;
	logic match_b_event;
	logic wrap_event;
	logic equal_a;
	logic equal_b;
	logic all_ones;
	logic write_control;
	logic write_status;
	logic read_status;
	logic [1:0] clock_select;
	logic [7:0] status_view;

	// Pin synchronisers for the external clock and the capture input
	pin_edge_sync u_ext_clock_sync (
		.core_clk_in(core_clk_in),
		.arst_n_in(arst_n_in),
		.pin_in(ext_clock_pin_in),
		.level_out(ext_level),
		.rise_out(ext_rise),
		.fall_out()
	);

	pin_edge_sync u_capture_sync (
		.core_clk_in(core_clk_in),
		.arst_n_in(arst_n_in),
		.pin_in(capture_pin_in),
		.level_out(cap_level),
		.rise_out(cap_rise),
		.fall_out(cap_fall)
	);

	// Access decode and assembled status view
	assign write_control = reg_write_hit(reg_wr_in, reg_sel_in, frt_ctrl_pkg::REG_TIMER_CONTROL);
	assign write_status = reg_write_hit(reg_wr_in, reg_sel_in,
		frt_ctrl_pkg::REG_TIMER_CONTROL_STATUS);
	assign read_status = reg_rd_in & (reg_sel_in == frt_ctrl_pkg::REG_TIMER_CONTROL_STATUS);
	assign status_view = {flags_r, plain_r};
	assign clock_select = {timer_control_r[frt_ctrl_pkg::CLOCK_SELECT_HI_BIT],
		timer_control_r[frt_ctrl_pkg::CLOCK_SELECT_LO_BIT]};

	// Counter comparisons against the value the counter holds right now
	assign equal_a = (running_counter_in == compare_a_value_in);
	assign equal_b = (running_counter_in == compare_b_value_in);
	assign all_ones = (running_counter_in == {COUNT_WIDTH{1'b1}});

	// Free divider of the system clock; cleared in standby
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			prescale_r <= '0;
		end else if (standby_in) begin
			prescale_r <= '0;
		end else begin
			prescale_r <= prescale_r + 5'h01;
		end
	end

	// Increment source: internal rate or synchronised external rising edge
	always_comb begin
		if (clock_select == frt_ctrl_pkg::CLK_EXTERNAL) begin
			count_pulse_nxt = ext_rise & ~standby_in;
		end else begin
			count_pulse_nxt = prescale_tick(clock_select, prescale_r) & ~standby_in;
		end
	end

	// Clear on match A replaces the increment of the cycle that advances past it
	assign counter_clear_nxt = count_pulse_nxt & equal_a
		& plain_r[frt_ctrl_pkg::CLEAR_ON_MATCH_A_BIT];

	// Increment and clear strobes to the external counter
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			count_pulse_r <= 1'h0;
			counter_clear_r <= 1'h0;
		end else begin
			count_pulse_r <= count_pulse_nxt;
			counter_clear_r <= counter_clear_nxt;
		end
	end

	// Events fire in the cycle the counter still equals, just before it moves
	assign match_a_event = count_pulse_r & equal_a;
	assign match_b_event = count_pulse_r & equal_b;
	assign wrap_event = count_pulse_r & all_ones & ~counter_clear_r;

	// Capture on the edge that status bit 1 selects, regardless of the flag
	always_comb begin
		if (plain_r[frt_ctrl_pkg::CAPTURE_EDGE_SELECT_BIT] == frt_ctrl_pkg::EDGE_RISING) begin
			capture_event = cap_rise & ~standby_in;
		end else begin
			capture_event = cap_fall & ~standby_in;
		end
	end

	// Capture load strobe to the external capture register
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			capture_load_r <= 1'h0;
		end else begin
			capture_load_r <= capture_event;
		end
	end

	// Control register; cleared by reset and standby, plain read/write otherwise
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			timer_control_r <= frt_ctrl_pkg::TIMER_CONTROL_RESET;
		end else if (standby_in) begin
			timer_control_r <= frt_ctrl_pkg::TIMER_CONTROL_RESET;
		end else if (write_control) begin
			timer_control_r <= reg_wdata_in;
		end
	end

	// Plain low half of the status register
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			plain_r <= frt_ctrl_pkg::TIMER_CONTROL_STATUS_RESET[3:0];
		end else if (standby_in) begin
			plain_r <= frt_ctrl_pkg::TIMER_CONTROL_STATUS_RESET[3:0];
		end else if (write_status) begin
			plain_r <= reg_wdata_in[3:0] & frt_ctrl_pkg::PLAIN_FIELD_MASK;
		end
	end

	// Flag set sources, one per flag position
	always_comb begin
		flag_set = 4'h0;
		flag_set[FIDX_CAPTURE] = capture_event;
		flag_set[FIDX_MATCH_B] = match_b_event;
		flag_set[FIDX_MATCH_A] = match_a_event;
		flag_set[FIDX_WRAP] = wrap_event;
	end

	// Flag update: a zero write clears only an armed flag; set beats clear
	genvar gi;
	generate
		for (gi = 0; gi < frt_ctrl_pkg::FLAG_COUNT; gi++) begin : g_flags
			logic xfer_clear;
			if (gi == FIDX_CAPTURE) begin : g_cap
				assign xfer_clear = xfer_clear_capture_in;
			end else if (gi == FIDX_MATCH_A) begin : g_ma
				assign xfer_clear = xfer_clear_match_a_in;
			end else if (gi == FIDX_MATCH_B) begin : g_mb
				assign xfer_clear = xfer_clear_match_b_in;
			end else begin : g_wrap
				assign xfer_clear = 1'h0;
			end
			// Writing one never sets; writing zero clears after a read of one
			assign flag_clear[gi] = (write_status & ~reg_wdata_in[gi + frt_ctrl_pkg::FLAG_LO_BIT]
				& read_armed_r[gi]) | xfer_clear;
			assign flags_nxt[gi] = flag_set[gi] | (flags_r[gi] & ~flag_clear[gi]);
			// Arm on a read that sees the flag set; any status write or a clear disarms
			always_comb begin
				if (read_status && flags_r[gi]) begin
					read_armed_nxt[gi] = 1'h1;
				end else if (write_status || !flags_r[gi]) begin
					read_armed_nxt[gi] = 1'h0;
				end else begin
					read_armed_nxt[gi] = read_armed_r[gi];
				end
			end
		end
	endgenerate

	// Flag and arm storage; cleared by reset and standby
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			flags_r <= frt_ctrl_pkg::TIMER_CONTROL_STATUS_RESET[7:4];
			read_armed_r <= 4'h0;
		end else if (standby_in) begin
			flags_r <= frt_ctrl_pkg::TIMER_CONTROL_STATUS_RESET[7:4];
			read_armed_r <= 4'h0;
		end else begin
			flags_r <= flags_nxt;
			read_armed_r <= read_armed_nxt;
		end
	end

	// Match pins start low and take the selected level at each enabled match
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			match_a_pin_r <= 1'h0;
		end else if (match_a_event && timer_control_r[frt_ctrl_pkg::MATCH_A_PIN_ENABLE_BIT]) begin
			match_a_pin_r <= plain_r[frt_ctrl_pkg::MATCH_A_LEVEL_BIT];
		end
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			match_b_pin_r <= 1'h0;
		end else if (match_b_event && timer_control_r[frt_ctrl_pkg::MATCH_B_PIN_ENABLE_BIT]) begin
			match_b_pin_r <= plain_r[frt_ctrl_pkg::MATCH_B_LEVEL_BIT];
		end
	end

	// Interrupt request levels: flag AND enable, registered
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			irq_r <= 4'h0;
		end else begin
			irq_r[FIDX_CAPTURE] <= flags_r[FIDX_CAPTURE]
				& timer_control_r[frt_ctrl_pkg::CAPTURE_IRQ_ENABLE_BIT];
			irq_r[FIDX_MATCH_B] <= flags_r[FIDX_MATCH_B]
				& timer_control_r[frt_ctrl_pkg::MATCH_B_IRQ_ENABLE_BIT];
			irq_r[FIDX_MATCH_A] <= flags_r[FIDX_MATCH_A]
				& timer_control_r[frt_ctrl_pkg::MATCH_A_IRQ_ENABLE_BIT];
			irq_r[FIDX_WRAP] <= flags_r[FIDX_WRAP]
				& timer_control_r[frt_ctrl_pkg::WRAP_IRQ_ENABLE_BIT];
		end
	end

	// Read data registered one cycle after the read strobe; holds otherwise
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			reg_rdata_r <= 8'h00;
		end else if (reg_rd_in) begin
			if (reg_sel_in == frt_ctrl_pkg::REG_TIMER_CONTROL_STATUS) begin
				reg_rdata_r <= status_view;
			end else begin
				reg_rdata_r <= timer_control_r;
			end
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata_out = reg_rdata_r;
	assign count_pulse_out = count_pulse_r;
	assign counter_clear_out = counter_clear_r;
	assign capture_load_out = capture_load_r;
	assign match_a_pin_out = match_a_pin_r;
	assign match_b_pin_out = match_b_pin_r;
	assign capture_irq_out = irq_r[FIDX_CAPTURE];
	assign match_a_irq_out = irq_r[FIDX_MATCH_A];
	assign match_b_irq_out = irq_r[FIDX_MATCH_B];
	assign wrap_irq_out = irq_r[FIDX_WRAP];

endmodule : frt_ctrl

`default_nettype wire

/* File: sim/frt_ctrl_monitor.sv */
// Checker of the timer channel control outputs
`timescale 1ns/1ns
`default_nettype none

module frt_ctrl_monitor #(
	parameter int COUNT_WIDTH = 16
) (
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic standby_in,
	input wire logic reg_wr_in,
	input wire logic [COUNT_WIDTH-1:0] running_counter_in,
	input wire logic [COUNT_WIDTH-1:0] compare_a_value_in,
	input wire logic [COUNT_WIDTH-1:0] compare_b_value_in,
	input wire logic xfer_clear_match_a_in,
	input wire logic count_pulse_out,
	input wire logic counter_clear_out,
	input wire logic capture_load_out,
	input wire logic match_a_pin_out,
	input wire logic match_b_pin_out,
	input wire logic capture_irq_out,
	input wire logic match_a_irq_out,
	input wire logic wrap_irq_out
);
	logic a_eq;
	logic b_eq;
	logic wrap_eq;

	// Match and wrap conditions in a counting cycle
	assign a_eq = count_pulse_out && (running_counter_in == compare_a_value_in);
	assign b_eq = count_pulse_out && (running_counter_in == compare_b_value_in);
	assign wrap_eq = count_pulse_out && !counter_clear_out && (running_counter_in == '1);

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);

	sequence a_hit;
		a_eq;
	endsequence

	sequence quiet_pulse;
		!count_pulse_out;
	endsequence

	clear_on_a_a: assert property (counter_clear_out |-> a_hit)
		else $error("counter clear without match A");
	pulse_gap_a: assert property (count_pulse_out |=> quiet_pulse)
		else $error("count pulses back to back");
	pin_a_cause_a: assert property ($changed(match_a_pin_out) |-> $past(a_eq))
		else $error("pin A moved without match");
	pin_b_cause_a: assert property ($changed(match_b_pin_out) |-> $past(b_eq))
		else $error("pin B moved without match");
	a_irq_drop_a: assert property ($fell(match_a_irq_out) |->
		$past(reg_wr_in, 2) || $past(xfer_clear_match_a_in, 2) || $past(standby_in, 2))
		else $error("match A request dropped without cause");
	wrap_drop_a: assert property ($fell(wrap_irq_out) |->
		$past(reg_wr_in, 2) || $past(standby_in, 2))
		else $error("wrap request dropped without cause");
	wrap_rise_a: assert property ($rose(wrap_irq_out) |->
		$past(wrap_eq, 2) || $past(reg_wr_in, 2))
		else $error("wrap request rose without cause");
	cap_irq_rise_a: assert property ($rose(capture_irq_out) |->
		$past(capture_load_out) || $past(reg_wr_in, 2))
		else $error("capture request rose without cause");
	cover property (counter_clear_out);
endmodule : frt_ctrl_monitor

bind frt_ctrl frt_ctrl_monitor #(.COUNT_WIDTH(COUNT_WIDTH)) mon (.*);
`default_nettype wire

/* File: sim/frt_counter_model.sv */
// Behavioural running counter that answers the control block's count pulses
`timescale 1ns/1ns
`default_nettype none

module frt_counter_model (
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic standby_in,
	input wire logic count_pulse_in,
	input wire logic counter_clear_in,
	input wire logic load_in,
	input wire logic [15:0] load_val_in,
	output logic [15:0] running_counter_out
);
	// Steps on each pulse; a match clear loads zero instead
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			running_counter_out <= 16'h0000;
		end else if (standby_in) begin
			running_counter_out <= 16'h0000;
		end else if (load_in) begin
			running_counter_out <= load_val_in;
		end else if (counter_clear_in) begin
			running_counter_out <= 16'h0000;
		end else if (count_pulse_in) begin
			running_counter_out <= running_counter_out + 16'h0001;
		end
	end
endmodule : frt_counter_model
`default_nettype wire

/* File: sim/frt_ctrl_tb.sv */
// Self-checking testbench of the timer channel control block
`timescale 1ns/1ns
`default_nettype none

module frt_ctrl_tb;
	logic core_clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic standby_in = 1'b0, reg_sel_in = 1'b0, reg_rd_in = 1'b0, reg_wr_in = 1'b0;
	logic ext_clock_pin_in = 1'b0, capture_pin_in = 1'b0, load = 1'b0;
	logic xfer_clear_capture_in = 1'b0, xfer_clear_match_a_in = 1'b0;
	logic xfer_clear_match_b_in = 1'b0;
	logic [7:0] reg_wdata_in = 8'h00, rv, reg_rdata_out;
	logic [15:0] running_counter_in, load_val = 16'h0000;
	logic [15:0] compare_a_value_in = 16'hF000, compare_b_value_in = 16'hF000;
	logic count_pulse_out, counter_clear_out, capture_load_out, match_a_pin_out;
	logic match_b_pin_out, capture_irq_out, match_a_irq_out, match_b_irq_out, wrap_irq_out;
	logic [5:0] obs;
	int err_total = 0, cmp_count = 0, loads = 0, ext_div = 0, n, g;
	int exp_ctl = 0, exp_sts = 0, armed = 0;
	integer seed = 32'hBBD2;

	always #2 core_clk_in = ~core_clk_in;
	assign obs = {count_pulse_out, capture_load_out, wrap_irq_out, match_b_irq_out,
		match_a_irq_out, capture_irq_out};

	frt_ctrl uut (.*);
	frt_counter_model cnt (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
		.standby_in(standby_in), .count_pulse_in(count_pulse_out),
		.counter_clear_in(counter_clear_out), .load_in(load), .load_val_in(load_val),
		.running_counter_out(running_counter_in));

	// External clock rises every 12 cycles; capture loads are counted
	always @(negedge core_clk_in) begin
		ext_div <= (ext_div == 5) ? 0 : ext_div + 1;
		if (ext_div == 5) ext_clock_pin_in <= ~ext_clock_pin_in;
		if (capture_load_out === 1'b1) loads <= loads + 1;
	end

	task check(input logic [15:0] seen, input logic [15:0] want);
		cmp_count++;
		if (seen !== want) begin
			err_total++;
			$display("ERROR %0t: seen %h want %h", $time, seen, want);
		end
	endtask : check

	task finish_test();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	task rd(input logic sel);
		@(negedge core_clk_in);
		reg_sel_in = sel;
		reg_rd_in = 1'b1;
		@(negedge core_clk_in);
		reg_rd_in = 1'b0;
		check(16'(reg_rdata_out), 16'(sel ? exp_sts : exp_ctl));
		if (sel) armed = exp_sts & 8'hF0;
	endtask : rd

	// Model: ones never set flags, zeros clear only armed flags
	task wr(input logic sel, input logic [7:0] v);
		@(negedge core_clk_in);
		reg_sel_in = sel;
		reg_wdata_in = v;
		reg_wr_in = 1'b1;
		@(negedge core_clk_in);
		reg_wr_in = 1'b0;
		if (!sel) begin
			exp_ctl = v;
		end else begin
			exp_sts = (exp_sts & ~(armed & ~v) & 8'hF0) | (v & 8'h0F);
			armed = 0;
		end
	endtask : wr

	task xclr(input logic [2:0] m);
		@(negedge core_clk_in);
		{xfer_clear_capture_in, xfer_clear_match_b_in, xfer_clear_match_a_in} = m;
		@(negedge core_clk_in);
		{xfer_clear_capture_in, xfer_clear_match_b_in, xfer_clear_match_a_in} = 3'b000;
		exp_sts = exp_sts & ~{m, 5'h00};
	endtask : xclr

	task await(input int w);
		n = 0;
		while (obs[w] !== 1'b1 && n < 400) begin
			@(negedge core_clk_in);
			n++;
		end
		if (n >= 400) begin
			err_total++;
			$display("ERROR %0t: wait %0d ran out", $time, w);
			finish_test();
		end
	endtask : await

	task gap();
		await(5);
		g = 0;
		do begin
			@(negedge core_clk_in);
			g++;
		end while (obs[5] !== 1'b1 && g < 100);
		if (g >= 100) begin
			err_total++;
			$display("ERROR %0t: pulse gap ran out", $time);
			finish_test();
		end
	endtask : gap

	// Match three counts ahead, then park the compare value again
	task hit(input int w, input logic [7:0] flag);
		@(negedge core_clk_in);
		if (w == 1) compare_a_value_in = running_counter_in + 16'h0003;
		else compare_b_value_in = running_counter_in + 16'h0003;
		await(w);
		compare_a_value_in = 16'hF000;
		compare_b_value_in = 16'hF000;
		exp_sts = exp_sts | flag;
	endtask : hit

	task cap(input logic v);
		@(negedge core_clk_in);
		capture_pin_in = v;
		repeat (8) @(negedge core_clk_in);
	endtask : cap

	initial begin
		repeat (12) @(negedge core_clk_in);
		arst_n_in = 1'b1;
		rd(0);
		rd(1);
		check({match_a_pin_out, match_b_pin_out, obs[3:0]}, 16'h0000);
		$display("test reset done");
		for (int c = 0; c < 4; c++) begin
			rv = 8'($random(seed));
			rv[1:0] = c[1:0];
			if (c == 3) rv[3] = 1'b0;
			wr(0, rv);
			rd(0);
			gap();
			gap();
			check(16'(g), 16'(c == 0 ? 4 : c == 1 ? 8 : c == 2 ? 32 : 12));
		end
		rv = 8'($random(seed));
		wr(1, rv | 8'hF0);
		rd(1);
		$display("test control done");
		wr(0, 8'h24);
		wr(1, 8'h05);
		hit(1, 8'h20);
		check({match_a_pin_out, match_a_irq_out}, 16'h0003);
		check(running_counter_in, 16'h0000);
		wr(1, 8'h05);
		rd(1);
		wr(1, 8'h01);
		rd(1);
		check(16'(match_a_irq_out), 16'h0000);
		hit(1, 8'h20);
		check(16'(match_a_pin_out), 16'h0000);
		xclr(3'b001);
		rd(1);
		wr(0, 8'h48);
		wr(1, 8'h08);
		hit(2, 8'h40);
		check({match_b_pin_out, match_a_pin_out}, 16'h0002);
		xclr(3'b010);
		rd(1);
		wr(0, 8'h40);
		wr(1, 8'h00);
		hit(2, 8'h40);
		check(16'(match_b_pin_out), 16'h0001);
		rd(1);
		wr(1, 8'h00);
		rd(1);
		$display("test compare done");
		wr(0, 8'h80);
		cap(1);
		check(16'(loads), 16'h0000);
		cap(0);
		exp_sts = exp_sts | 8'h80;
		check({15'(loads), capture_irq_out}, 16'h0003);
		rd(1);
		wr(1, 8'h82);
		cap(1);
		check(16'(loads), 16'h0002);
		xclr(3'b100);
		rd(1);
		wr(0, 8'h00);
		cap(0);
		cap(1);
		exp_sts = exp_sts | 8'h80;
		check({15'(loads), capture_irq_out}, 16'h0006);
		rd(1);
		$display("test capture done");
		wr(0, 8'h10);
		@(negedge core_clk_in);
		load_val = 16'hFFF0;
		load = 1'b1;
		@(negedge core_clk_in);
		load = 1'b0;
		await(3);
		exp_sts = exp_sts | 8'h10;
		xclr(3'b111);
		rd(1);
		wr(1, 8'h00);
		rd(1);
		check(16'(wrap_irq_out), 16'h0000);
		$display("test wrap done");
		wr(0, 8'h64);
		wr(1, 8'h0C);
		@(negedge core_clk_in);
		standby_in = 1'b1;
		repeat (2) @(negedge core_clk_in);
		standby_in = 1'b0;
		exp_ctl = 0;
		exp_sts = 0;
		armed = 0;
		rd(0);
		rd(1);
		check(16'(match_b_pin_out), 16'h0001);
		$display("test standby done");
		finish_test();
	end
endmodule : frt_ctrl_tb
`default_nettype wire
